// ---- rtl/oscdc_pkg.sv ----
// oscdc_pkg: constants, register map and carrier types for the oscillator select and divider control
// assumes a 16-bit register port and configuration straps that hold steady until captured in the first cycle after internal reset release
// Function
// - new-source field codes: 000 rc, 001 rc+pll, 010 primary, 011 primary+pll, 100..111 others
// - primary submode 10 high speed, 01 crystal, 00 external; ignored for other sources
// - erased initial source configuration starts on fast rc divided by n, code 111
// - current-source field bits 14-12 is read-only and reports the active source
// - with switching on and monitor off, switch_lock set blocks requests in later writes, not one in the write that sets it or a switch under way
// - pin_select_lock bit 6 set rejects pin-select writes, clear accepts them
// - pll-locked bit 5 reads 1 when locked while the current or new source uses the pll, else 0
// - clock_fail_flag bit 3 set on monitor failure; software reads and clears it
// - secondary_osc_enable bit 1 turns the secondary oscillator on or off
// - writing 1 to switch_request starts a switch; hardware clears it when done
// - recover_on_interrupt set makes any interrupt clear reduction_enable
// - reduction field divides instruction clock by 2^value, default 011 (divide by 8)
// - reduction_enable 1 applies reduction ratio; 0 forces ratio 1:1
// - rc_postscale codes 000..110 divide by 1..64, 111 by 256, default 1
// - pll_post_divider 00 /2, 01 /4 default, 11 /8, 10 reserved
// - pll_pre_divider divides by value plus two, default 00000 (divide by 2)
// - pll_feedback_mult multiplies by value plus two, default 000110000 (50)
// - rc_trim is two's complement in 0.375 percent steps, zero nominal
// - switching may reach primary but never changes the configured primary submode
// - switching enabled only when switch_monitor_cfg is 0; 1 disables switching and monitor
// - with switching disabled new-source has no effect; current shows initial configuration
// - with switching disabled switch_request ignores writes and reads 0
// - request with current equal to new clears switch_request and aborts
// - valid switch clears lock and fail flags, then waits for timer, pll lock, or both for primary+pll
// - after ready, wait 10 new-source cycles, switch, clear request, copy new to current
// - monitor failure raises a trap and moves the system clock to fast rc
package oscdc_pkg;
    // ====================================================================
    // register indices on the plain register port
    localparam logic [1:0] OSCDC_ADDR_OSC_CTRL = 2'h0;
    localparam logic [1:0] OSCDC_ADDR_CLK_DIV  = 2'h1;
    localparam logic [1:0] OSCDC_ADDR_PLL_FBD  = 2'h2;
    localparam logic [1:0] OSCDC_ADDR_RC_TUNE  = 2'h3;
    // ====================================================================
    // oscillator_control field positions
    localparam int OSCDC_CUR_LSB  = 12;
    localparam int OSCDC_NEW_LSB  = 8;
    localparam int OSCDC_SWLK_BIT = 7;
    localparam int OSCDC_PSLK_BIT = 6;
    localparam int OSCDC_LOCK_BIT = 5;
    localparam int OSCDC_FAIL_BIT = 3;
    localparam int OSCDC_SECONDARY_OSC_BIT = 1;
    localparam int OSCDC_SREQ_BIT = 0;
    // clock_divisor field positions
    localparam int OSCDC_ROI_BIT  = 15;
    localparam int OSCDC_RED_LSB  = 12;
    localparam int OSCDC_REDE_BIT = 11;
    localparam int OSCDC_RCPS_LSB = 8;
    localparam int OSCDC_POST_LSB = 6;
    localparam int OSCDC_PRE_LSB  = 0;
    // ====================================================================
    // source selection codes
    localparam logic [2:0] OSCDC_SRC_FRC     = 3'h0;
    localparam logic [2:0] OSCDC_SRC_FAST_RC_WITH_PLL_MODE  = 3'h1;
    localparam logic [2:0] OSCDC_SRC_PRI     = 3'h2;
    localparam logic [2:0] OSCDC_SRC_PRIPLL  = 3'h3;
    localparam logic [2:0] OSCDC_SRC_SEC     = 3'h4;
    localparam logic [2:0] OSCDC_SRC_LOW_POWER_RC_OSC    = 3'h5;
    localparam logic [2:0] OSCDC_SRC_FRC16   = 3'h6;
    localparam logic [2:0] OSCDC_SRC_FAST_RC_DIV_N_MODE = 3'h7;
    // primary submodes
    localparam logic [1:0] OSCDC_PM_EC = 2'h0;
    localparam logic [1:0] OSCDC_PM_XT = 2'h1;
    localparam logic [1:0] OSCDC_PM_HS = 2'h2;
    // reset values and the reserved post divider code
    localparam logic [2:0] OSCDC_RED_RST  = 3'h3;
    localparam logic [2:0] OSCDC_RCPS_RST = 3'h0;
    localparam logic [1:0] OSCDC_POST_RST = 2'h1;
    localparam logic [4:0] OSCDC_PRE_RST  = 5'h00;
    localparam logic [8:0] OSCDC_MULT_RST = 9'h030;
    localparam logic [5:0] OSCDC_TRIM_RST = 6'h00;
    localparam logic [1:0] OSCDC_POST_RSVD = 2'h2;
    // cycles of the new source to wait before switching
    localparam logic [3:0] OSCDC_SETTLE_CYC = 4'hA;

    typedef struct packed {
        logic [1:0]  addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } oscdc_bus_t;

    typedef struct packed {
        logic [2:0] source;        // active source code
        logic [1:0] primary_mode;  // fixed by configuration
        logic [2:0] rc_postscale;
        logic [1:0] pll_post;
        logic [4:0] pll_pre;
        logic [8:0] pll_mult;
        logic [5:0] rc_trim;
        logic [7:0] cpu_div_log2;  // 0 when ratio forced 1:1
        logic       sec_osc_on;
        logic       pin_sel_lock;
        logic       monitor_on;
    } oscdc_clk_cfg_t;

    typedef enum logic [4:0] {
        OSCDC_IDLE   = 5'b00001,
        OSCDC_READY  = 5'b00010,
        OSCDC_SETTLE = 5'b00100,
        OSCDC_COMMIT = 5'b01000,
        OSCDC_FAIL   = 5'b10000
    } oscdc_state_t;
endpackage

// ---- rtl/oscdc_sync.sv ----
// oscdc_sync: three-stage synchroniser with agreement filter for asynchronous levels
// assumes the input is a level from another clock domain
`timescale 1ns/1ps
`default_nettype none
module oscdc_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output var  logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] q_nxt;

    // a change counts only once stages two and three agree
    always_comb
    begin
        q_nxt = q;
        for (int i = 0; i < W; i++)
        begin
            if (s2_r[i] == s3_r[i])
            begin
                q_nxt[i] = s3_r[i];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            q    <= '0;
        end
        else
        begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q    <= q_nxt;
        end
    end
endmodule
`default_nettype wire

// ---- rtl/oscdc_ctrl.sv ----
// oscdc_ctrl: oscillator select, switch sequencer and divider registers
// assumes pll_locked, startup_done, new_src_tick and clock_failure come from analog clock domains
`timescale 1ns/1ps
`default_nettype none
module oscdc_ctrl
    import oscdc_pkg::*;
(
    input  wire logic                      core_clk,
    input  wire logic                      resetn,
    input  wire oscdc_pkg::oscdc_bus_t     bus,
    output var  logic [15:0]               rdata,
    input  wire logic [2:0]                initial_source_cfg,
    input  wire logic [1:0]                primary_submode_cfg,
    input  wire logic                      switch_monitor_cfg,
    input  wire logic                      monitor_disable_cfg,
    input  wire logic                      pll_locked,
    input  wire logic                      startup_done,
    input  wire logic                      new_src_tick,
    input  wire logic                      clock_failure,
    input  wire logic                      interrupt_event,
    input  wire logic                      pin_sel_wr,
    output var  logic                      pin_sel_wr_ok,
    output var  logic                      fail_trap,
    output var  oscdc_pkg::oscdc_clk_cfg_t clk_cfg
);
    // ====================================================================
    // reset release
    logic rst_a_r;
    logic rst_n;
    always_ff @(posedge core_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rst_a_r <= 1'b0;
            rst_n   <= 1'b0;
        end
        else
        begin
            rst_a_r <= 1'b1;
            rst_n   <= rst_a_r;
        end
    end

    // ====================================================================
    // pin inputs
    logic [3:0] async_s;
    oscdc_sync #(.W(4)) u_sync (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .d        ({pll_locked, startup_done, new_src_tick, clock_failure}),
        .q        (async_s)
    );
    logic lock_s;
    logic ost_s;
    logic tick_s;
    logic fail_s;
    logic tick_d_r;
    logic fail_d_r;
    assign {lock_s, ost_s, tick_s, fail_s} = async_s;

    // ====================================================================
    // configuration capture after reset release
    logic       cap_done_r;
    logic [2:0] init_src_r;
    logic [1:0] pri_mode_r;
    logic       sw_en_r;
    logic       mon_en_r;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cap_done_r <= 1'b0;
            init_src_r <= OSCDC_SRC_FAST_RC_DIV_N_MODE;
            pri_mode_r <= OSCDC_PM_EC;
            sw_en_r    <= 1'b0;
            mon_en_r   <= 1'b0;
        end
        else if (!cap_done_r)
        begin
            cap_done_r <= 1'b1;
            init_src_r <= initial_source_cfg;
            pri_mode_r <= primary_submode_cfg;
            sw_en_r    <= !switch_monitor_cfg;
            mon_en_r   <= !switch_monitor_cfg && !monitor_disable_cfg;
        end
    end

    // ====================================================================
    // registers and switch sequencer
    oscdc_state_t state_r,  state_nxt;
    logic [2:0] cur_r,      cur_nxt;
    logic [2:0] new_r,      new_nxt;
    logic       swlk_r,     swlk_nxt;
    logic       pslk_r,     pslk_nxt;
    logic       lockf_r,    lockf_nxt;
    logic       fail_r,     fail_nxt;
    logic       secondary_osc_r,     secondary_osc_nxt;
    logic       sreq_r,     sreq_nxt;
    logic       roi_r,      roi_nxt;
    logic [2:0] red_r,      red_nxt;
    logic       rede_r,     rede_nxt;
    logic [2:0] rcps_r,     rcps_nxt;
    logic [1:0] post_r,     post_nxt;
    logic [4:0] pre_r,      pre_nxt;
    logic [8:0] mult_r,     mult_nxt;
    logic [5:0] trim_r,     trim_nxt;
    logic [3:0] cnt_r,      cnt_nxt;
    logic       trap_nxt;
    logic       wr_osc;
    logic       wr_div;
    logic       need_pll;
    logic       need_ost;
    logic       src_ready;

    assign wr_osc = bus.wr && (bus.addr == OSCDC_ADDR_OSC_CTRL);
    assign wr_div = bus.wr && (bus.addr == OSCDC_ADDR_CLK_DIV);
    assign need_pll = (new_r == OSCDC_SRC_FAST_RC_WITH_PLL_MODE) || (new_r == OSCDC_SRC_PRIPLL);
    assign need_ost = (new_r == OSCDC_SRC_PRI) || (new_r == OSCDC_SRC_PRIPLL) || (new_r == OSCDC_SRC_SEC);
    // crystal sources wait for the start-up timer, pll sources for lock
    assign src_ready = (!need_pll || lock_s) && (!need_ost || ost_s);

    always_comb
    begin
        state_nxt = state_r;
        cur_nxt   = cap_done_r ? cur_r : initial_source_cfg;
        new_nxt   = cap_done_r ? new_r : initial_source_cfg;
        swlk_nxt  = swlk_r;
        pslk_nxt  = pslk_r;
        lockf_nxt = 1'b0;
        fail_nxt  = fail_r;
        secondary_osc_nxt  = secondary_osc_r;
        sreq_nxt  = sreq_r;
        roi_nxt   = roi_r;
        red_nxt   = red_r;
        rede_nxt  = rede_r;
        rcps_nxt  = rcps_r;
        post_nxt  = post_r;
        pre_nxt   = pre_r;
        mult_nxt  = mult_r;
        trim_nxt  = trim_r;
        cnt_nxt   = cnt_r;
        trap_nxt  = 1'b0;
        if (need_pll || cur_r == OSCDC_SRC_FAST_RC_WITH_PLL_MODE || cur_r == OSCDC_SRC_PRIPLL)
        begin
            lockf_nxt = lock_s;
        end
        if (wr_osc)
        begin
            if (sw_en_r)
            begin
                new_nxt = bus.wdata[OSCDC_NEW_LSB +: 3];
            end
            swlk_nxt = bus.wdata[OSCDC_SWLK_BIT];
            pslk_nxt = bus.wdata[OSCDC_PSLK_BIT];
            secondary_osc_nxt = bus.wdata[OSCDC_SECONDARY_OSC_BIT];
            fail_nxt = fail_r && bus.wdata[OSCDC_FAIL_BIT];
            // request taken only when idle, allowed and not blocked by switch_lock with the monitor off
            if (bus.wdata[OSCDC_SREQ_BIT] && sw_en_r && state_r == OSCDC_IDLE
                && !(swlk_r && !mon_en_r))
            begin
                sreq_nxt = 1'b1;
            end
        end
        if (wr_div)
        begin
            roi_nxt  = bus.wdata[OSCDC_ROI_BIT];
            red_nxt  = bus.wdata[OSCDC_RED_LSB +: 3];
            rede_nxt = bus.wdata[OSCDC_REDE_BIT];
            rcps_nxt = bus.wdata[OSCDC_RCPS_LSB +: 3];
            if (bus.wdata[OSCDC_POST_LSB +: 2] != OSCDC_POST_RSVD)
            begin
                post_nxt = bus.wdata[OSCDC_POST_LSB +: 2];
            end
            pre_nxt  = bus.wdata[OSCDC_PRE_LSB +: 5];
        end
        mult_nxt = (bus.wr && bus.addr == OSCDC_ADDR_PLL_FBD) ? bus.wdata[8:0] : mult_r;
        trim_nxt = (bus.wr && bus.addr == OSCDC_ADDR_RC_TUNE) ? bus.wdata[5:0] : trim_r;
        // an interrupt wins over a same-cycle software write of the enable
        rede_nxt = rede_nxt && !(roi_r && interrupt_event);
        case (state_r)
            OSCDC_IDLE:
            begin
                if (sreq_r)
                begin
                    if (cur_r == new_r)
                    begin
                        sreq_nxt = 1'b0;
                    end
                    else
                    begin
                        fail_nxt  = 1'b0;
                        lockf_nxt = 1'b0;
                        state_nxt = OSCDC_READY;
                    end
                end
            end
            OSCDC_READY:
            begin
                cnt_nxt = '0;
                if (src_ready)
                begin
                    state_nxt = OSCDC_SETTLE;
                end
            end
            OSCDC_SETTLE:
            begin
                if (tick_s && !tick_d_r)
                begin
                    cnt_nxt = cnt_r + 4'h1;
                end
                if (cnt_r == OSCDC_SETTLE_CYC)
                begin
                    state_nxt = OSCDC_COMMIT;
                end
            end
            OSCDC_COMMIT:
            begin
                cur_nxt   = new_r;
                sreq_nxt  = 1'b0;
                state_nxt = OSCDC_IDLE;
            end
            default:
            begin
                state_nxt = OSCDC_IDLE;
            end
        endcase
        // monitor failure preempts any switch; set wins over software clear
        if (mon_en_r && fail_s && !fail_d_r)
        begin
            fail_nxt  = 1'b1;
            trap_nxt  = 1'b1;
            cur_nxt   = OSCDC_SRC_FRC;
            sreq_nxt  = 1'b0;
            state_nxt = OSCDC_FAIL;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_r   <= OSCDC_IDLE;
            cur_r     <= OSCDC_SRC_FAST_RC_DIV_N_MODE;
            new_r     <= OSCDC_SRC_FAST_RC_DIV_N_MODE;
            swlk_r    <= 1'b0;
            pslk_r    <= 1'b0;
            lockf_r   <= 1'b0;
            fail_r    <= 1'b0;
            secondary_osc_r    <= 1'b0;
            sreq_r    <= 1'b0;
            roi_r     <= 1'b0;
            red_r     <= OSCDC_RED_RST;
            rede_r    <= 1'b0;
            rcps_r    <= OSCDC_RCPS_RST;
            post_r    <= OSCDC_POST_RST;
            pre_r     <= OSCDC_PRE_RST;
            mult_r    <= OSCDC_MULT_RST;
            trim_r    <= OSCDC_TRIM_RST;
            cnt_r     <= '0;
            tick_d_r  <= 1'b0;
            fail_d_r  <= 1'b0;
            fail_trap <= 1'b0;
        end
        else
        begin
            state_r   <= state_nxt;
            cur_r     <= cur_nxt;
            new_r     <= new_nxt;
            swlk_r    <= swlk_nxt;
            pslk_r    <= pslk_nxt;
            lockf_r   <= lockf_nxt;
            fail_r    <= fail_nxt;
            secondary_osc_r    <= secondary_osc_nxt;
            sreq_r    <= sreq_nxt;
            roi_r     <= roi_nxt;
            red_r     <= red_nxt;
            rede_r    <= rede_nxt;
            rcps_r    <= rcps_nxt;
            post_r    <= post_nxt;
            pre_r     <= pre_nxt;
            mult_r    <= mult_nxt;
            trim_r    <= trim_nxt;
            cnt_r     <= cnt_nxt;
            tick_d_r  <= tick_s;
            fail_d_r  <= fail_s;
            fail_trap <= trap_nxt;
        end
    end

    // ====================================================================
    // read data and outward configuration
    logic [15:0]    rdata_nxt;
    oscdc_clk_cfg_t cfg_nxt;
    always_comb
    begin
        rdata_nxt = '0;
        if (bus.rd)
        begin
            case (bus.addr)
                OSCDC_ADDR_OSC_CTRL:
                begin
                    rdata_nxt[OSCDC_CUR_LSB +: 3] = cur_r;
                    rdata_nxt[OSCDC_NEW_LSB +: 3] = new_r;
                    rdata_nxt[OSCDC_SWLK_BIT]     = swlk_r;
                    rdata_nxt[OSCDC_PSLK_BIT]     = pslk_r;
                    rdata_nxt[OSCDC_LOCK_BIT]     = lockf_r;
                    rdata_nxt[OSCDC_FAIL_BIT]     = fail_r;
                    rdata_nxt[OSCDC_SECONDARY_OSC_BIT]     = secondary_osc_r;
                    rdata_nxt[OSCDC_SREQ_BIT]     = sreq_r && sw_en_r;
                end
                OSCDC_ADDR_CLK_DIV:
                begin
                    rdata_nxt[OSCDC_ROI_BIT]       = roi_r;
                    rdata_nxt[OSCDC_RED_LSB +: 3]  = red_r;
                    rdata_nxt[OSCDC_REDE_BIT]      = rede_r;
                    rdata_nxt[OSCDC_RCPS_LSB +: 3] = rcps_r;
                    rdata_nxt[OSCDC_POST_LSB +: 2] = post_r;
                    rdata_nxt[OSCDC_PRE_LSB +: 5]  = pre_r;
                end
                OSCDC_ADDR_PLL_FBD:
                begin
                    rdata_nxt[8:0] = mult_r;
                end
                OSCDC_ADDR_RC_TUNE:
                begin
                    rdata_nxt[5:0] = trim_r;
                end
                default:
                begin
                    rdata_nxt = '0;
                end
            endcase
        end
        cfg_nxt.source       = cur_r;
        cfg_nxt.primary_mode = pri_mode_r;
        cfg_nxt.rc_postscale = rcps_r;
        cfg_nxt.pll_post     = post_r;
        cfg_nxt.pll_pre      = pre_r;
        cfg_nxt.pll_mult     = mult_r;
        cfg_nxt.rc_trim      = trim_r;
        cfg_nxt.cpu_div_log2 = rede_r ? {5'h00, red_r} : 8'h00;
        cfg_nxt.sec_osc_on   = secondary_osc_r;
        cfg_nxt.pin_sel_lock = pslk_r;
        cfg_nxt.monitor_on   = mon_en_r;
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rdata         <= '0;
            clk_cfg       <= '0;
            pin_sel_wr_ok <= 1'b0;
        end
        else
        begin
            rdata         <= rdata_nxt;
            clk_cfg       <= cfg_nxt;
            pin_sel_wr_ok <= pin_sel_wr && !pslk_r;
        end
    end
endmodule
`default_nettype wire

// ---- testbench/oscdc_ctrl_asserts.sv ----
// oscdc_ctrl_asserts: port-level timing relations of the oscillator select and divider control
// assumes it is bound into every oscdc_ctrl instance and sees only that module's ports
`timescale 1ns/1ps
`default_nettype none
module oscdc_ctrl_asserts
    import oscdc_pkg::*;
(
    input wire logic                      core_clk,
    input wire logic                      resetn,
    input wire oscdc_pkg::oscdc_bus_t     bus,
    input wire logic [15:0]               rdata,
    input wire logic                      clock_failure,
    input wire logic                      pin_sel_wr,
    input wire logic                      pin_sel_wr_ok,
    input wire logic                      fail_trap,
    input wire oscdc_pkg::oscdc_clk_cfg_t clk_cfg
);
    // ====================================================================
    // checks
    default clocking @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_rdata_quiet: assert property ($past(bus.rd) == 1'b0 |-> rdata == 16'h0000)
        else $error("read data outside read slot");
    // the output lock lags the internal one by a cycle, so it matches the accept flag one cycle on
    a_pin_pass: assert property (pin_sel_wr |=> pin_sel_wr_ok || clk_cfg.pin_sel_lock)
        else $error("unlocked pin write refused");
    a_pin_block: assert property (pin_sel_wr |=> !(pin_sel_wr_ok && clk_cfg.pin_sel_lock))
        else $error("locked pin write accepted");
    a_trap_once: assert property (fail_trap |=> !fail_trap) else $error("trap longer than one cycle");
    a_trap_frc: assert property (fail_trap |-> ##[0:2] clk_cfg.source == OSCDC_SRC_FRC)
        else $error("no fall back to fast rc");
    a_trap_cause: assert property (fail_trap |-> clk_cfg.monitor_on && clock_failure)
        else $error("trap without failure");
    a_post_legal: assert property (clk_cfg.pll_post != OSCDC_POST_RSVD)
        else $error("reserved post divider applied");
    a_cur_hold: assert property (bus.wr && bus.addr == OSCDC_ADDR_OSC_CTRL && !clock_failure |=>
        $stable(clk_cfg.source)) else $error("source written directly");
    a_doze_ratio: assert property ($past(bus.rd) && $past(bus.addr) == OSCDC_ADDR_CLK_DIV |->
        clk_cfg.cpu_div_log2 == (rdata[OSCDC_REDE_BIT] ? {5'h00, rdata[OSCDC_RED_LSB +: 3]} : 8'h00))
        else $error("reduction ratio differs from register");
endmodule
bind oscdc_ctrl oscdc_ctrl_asserts oscdc_ctrl_asserts_i (.core_clk, .resetn, .bus, .rdata, .clock_failure,
    .pin_sel_wr, .pin_sel_wr_ok, .fail_trap, .clk_cfg);
`default_nettype wire

// ---- testbench/oscdc_ctrl_tb_top.sv ----
// oscdc_ctrl_tb_top: self-checking bench for the oscillator select and divider control
// assumes the checker binds itself; analog levels are driven directly by the bench
`timescale 1ns/1ps
`default_nettype none
module oscdc_ctrl_tb_top;
    import oscdc_pkg::*;
    logic           core_clk = 1'b0;
    logic           resetn = 1'b0;
    oscdc_bus_t     bus = '0;
    logic [15:0]    rdata;
    logic [2:0]     initial_source_cfg = 3'h7;
    logic           switch_monitor_cfg = 1'b0;
    logic           monitor_disable_cfg = 1'b0;
    logic           startup_done = 1'b0;
    logic           pll_locked = 1'b0;
    logic           new_src_tick = 1'b0;
    logic           clock_failure = 1'b0;
    logic           interrupt_event = 1'b0;
    logic           pin_sel_wr = 1'b0;
    logic           pin_sel_wr_ok;
    logic           fail_trap;
    oscdc_clk_cfg_t clk_cfg;
    int             fails = 0;
    int             check_count = 0;
    int             cycles = 0;
    logic [15:0]    got;
    logic [15:0]    rst_vals [4] = '{16'h7700, 16'h3040, 16'h0030, 16'h0000};
    // address, write data, expected read back
    logic [33:0]    rows [8] = '{{OSCDC_ADDR_CLK_DIV, 16'hFFFF, 16'hFFDF}, {OSCDC_ADDR_CLK_DIV, 16'h0000, 16'h0000},
        {OSCDC_ADDR_PLL_FBD, 16'hFFFF, 16'h01FF}, {OSCDC_ADDR_PLL_FBD, 16'h0000, 16'h0000},
        {OSCDC_ADDR_RC_TUNE, 16'hFFFF, 16'h003F}, {OSCDC_ADDR_RC_TUNE, 16'h0020, 16'h0020},
        {OSCDC_ADDR_OSC_CTRL, 16'h0702, 16'h7702}, {OSCDC_ADDR_OSC_CTRL, 16'h0700, 16'h7700}};

    oscdc_ctrl oscdc_ctrl_i (.core_clk, .resetn, .bus, .rdata, .initial_source_cfg, .primary_submode_cfg(2'h1),
        .switch_monitor_cfg, .monitor_disable_cfg, .pll_locked, .startup_done, .new_src_tick,
        .clock_failure, .interrupt_event, .pin_sel_wr, .pin_sel_wr_ok, .fail_trap, .clk_cfg);

    // ====================================================================
    // clocks, timeout and bus tasks
    always #2.5 core_clk = ~core_clk;
    // the new source runs unrelated to the core clock
    always #13 new_src_tick = ~new_src_tick;
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fails++;
            close_out();
        end
    end

    task automatic close_out();
        if (fails == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic cmp(input logic [15:0] g, input logic [15:0] e, input logic [15:0] m);
        check_count++;
        if ((g & m) !== (e & m))
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    // a gap cycle after each strobe keeps one assignment per time step
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus <= '0;
        @(posedge core_clk);
    endtask

    task automatic rd(input logic [1:0] a);
        bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
        @(posedge core_clk);
        bus <= '0;
        // read data stand only in the cycle right after the strobe
        #1 got = rdata;
        @(posedge core_clk);
    endtask

    task automatic poll(input logic [1:0] a, input logic [15:0] e, input logic [15:0] m);
        int n;
        n = 0;
        do
        begin
            rd(a);
            n++;
        end
        while ((got & m) !== (e & m) && n < 80);
        cmp(got, e, m);
    endtask

    task automatic pin(input logic e);
        pin_sel_wr <= 1'b1;
        @(posedge core_clk);
        pin_sel_wr <= 1'b0;
        #1 cmp({15'h0, pin_sel_wr_ok}, {15'h0, e}, 16'h0001);
        @(posedge core_clk);
    endtask

    task automatic restart(input logic sw, input logic mon, input logic [2:0] src);
        resetn <= 1'b0;
        switch_monitor_cfg <= sw;
        monitor_disable_cfg <= mon;
        initial_source_cfg <= src;
        repeat (3) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (5) @(posedge core_clk);
    endtask

    // ====================================================================
    // main sequence
    initial
    begin
        restart(1'b0, 1'b0, 3'h7);
        for (int i = 0; i < 4; i++)
        begin
            rd(i[1:0]);
            cmp(got, rst_vals[i], 16'hFFFF);
        end
        foreach (rows[i])
        begin
            wr(rows[i][33:32], rows[i][31:16]);
            rd(rows[i][33:32]);
            cmp(got, rows[i][15:0], 16'hFFFF);
        end
        wr(OSCDC_ADDR_CLK_DIV, 16'hB8C0);
        wr(OSCDC_ADDR_CLK_DIV, 16'hB880);
        rd(OSCDC_ADDR_CLK_DIV);
        cmp(got, 16'hB8C0, 16'hFFFF);
        cmp({8'h00, clk_cfg.cpu_div_log2}, 16'h0003, 16'hFFFF);
        interrupt_event <= 1'b1;
        @(posedge core_clk);
        interrupt_event <= 1'b0;
        rd(OSCDC_ADDR_CLK_DIV);
        cmp(got, 16'hB0C0, 16'hFFFF);
        cmp({8'h00, clk_cfg.cpu_div_log2}, 16'h0000, 16'hFFFF);
        wr(OSCDC_ADDR_OSC_CTRL, 16'h0740);
        pin(1'b0);
        wr(OSCDC_ADDR_OSC_CTRL, 16'h0700);
        pin(1'b1);
        wr(OSCDC_ADDR_OSC_CTRL, 16'h0201);
        rd(OSCDC_ADDR_OSC_CTRL);
        cmp(got, 16'h7201, 16'hFFFF);
        startup_done <= 1'b1;
        poll(OSCDC_ADDR_OSC_CTRL, 16'h2200, 16'hFFFF);
        cmp({11'h0, clk_cfg.source, clk_cfg.primary_mode}, 16'h0009, 16'hFFFF);
        wr(OSCDC_ADDR_OSC_CTRL, 16'h0201);
        rd(OSCDC_ADDR_OSC_CTRL);
        cmp(got, 16'h2200, 16'hFFFF);
        clock_failure <= 1'b1;
        poll(OSCDC_ADDR_OSC_CTRL, 16'h0008, 16'h7008);
        clock_failure <= 1'b0;
        repeat (8) @(posedge core_clk);
        wr(OSCDC_ADDR_OSC_CTRL, 16'h0000);
        rd(OSCDC_ADDR_OSC_CTRL);
        cmp(got, 16'h0000, 16'h0008);
        pll_locked <= 1'b1;
        wr(OSCDC_ADDR_OSC_CTRL, 16'h0101);
        poll(OSCDC_ADDR_OSC_CTRL, 16'h1120, 16'hFFFF);
        restart(1'b1, 1'b0, 3'h6);
        wr(OSCDC_ADDR_OSC_CTRL, 16'h0201);
        repeat (20) @(posedge core_clk);
        rd(OSCDC_ADDR_OSC_CTRL);
        cmp(got, 16'h6000, 16'h7021);
        cmp({13'h0, clk_cfg.source}, 16'h0006, 16'hFFFF);
        restart(1'b0, 1'b1, 3'h7);
        wr(OSCDC_ADDR_OSC_CTRL, 16'h0780);
        wr(OSCDC_ADDR_OSC_CTRL, 16'h0281);
        repeat (20) @(posedge core_clk);
        rd(OSCDC_ADDR_OSC_CTRL);
        cmp(got, 16'h7000, 16'h7001);
        close_out();
    end
endmodule
`default_nettype wire
